//--- common/modulo_timer_defs.svh
// Constants for the modulo timer
`ifndef MODULO_TIMER_DEFS_SVH
`define MODULO_TIMER_DEFS_SVH

`define MODULO_TIMER_CNT_RST 8'h00
`define MODULO_TIMER_MOD_RST 8'h00
`define MODULO_TIMER_PRE_RST 8'h00
`define MODULO_TIMER_CNT_MAX 8'hff
`define MODULO_TIMER_CNT_INC 8'h01
`define MODULO_TIMER_PS_RST  4'h0
`define MODULO_TIMER_PS_MAX  4'h8
`define MODULO_TIMER_MASK_ALL 8'hff

`endif

//--- common/modulo_timer_pkg.sv
// Types shared by the modulo timer modules
package modulo_timer_pkg;

   // Clock source codes, in select order
   typedef enum logic [1:0] {
      MODULO_TIMER_SRC_BUS,
      MODULO_TIMER_SRC_FIXED,
      MODULO_TIMER_SRC_PIN_FALL,
      MODULO_TIMER_SRC_PIN_RISE
   } modulo_timer_src_e;

   // Fields of one status and control write
   typedef struct packed {
      logic       overflow_flag;
      logic       overflow_irq_enable;
      logic       counter_reset;
      logic       counter_stop_bit;
      logic [1:0] clock_source_select;
      logic [3:0] prescale_select;
   } modulo_timer_ctrl_s;

   // Status and control readback
   typedef struct packed {
      logic       overflow_flag;
      logic       overflow_irq_enable;
      logic       counter_reset;
      logic       counter_stop_bit;
      logic [1:0] clock_source_select;
      logic [3:0] prescale_select;
   } modulo_timer_stat_s;

endpackage : modulo_timer_pkg

//--- logic/modulo_timer_core.sv
// Modulo timer: counter, prescaler, source select and overflow flag
`timescale 1ns/1ps
`include "modulo_timer_defs.svh"
module modulo_timer_core (
   input  wire logic            clk,
   input  wire logic            rst_n,
   input  wire logic            fixed_freq_clock,
   input  wire logic            external_count_pin,
   input  wire logic            status_rd,
   input  wire logic            ctrl_wr,
   input  wire modulo_timer_pkg::modulo_timer_ctrl_s ctrl_data,
   input  wire logic            mod_wr,
   input  wire logic [7:0]      mod_data,
   output modulo_timer_pkg::modulo_timer_stat_s timer_status_control,
   output logic [7:0]           count_value,
   output logic [7:0]           rollover_compare_value,
   output logic                 overflow_irq
);

   // Reset release synchroniser
   logic rst_meta_q;
   logic rst_s_n;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_q <= 1'b0;
         rst_s_n    <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_s_n    <= rst_meta_q;
      end
   end

   // Configuration state
   logic                stop_q;
   logic                stop_d;
   modulo_timer_pkg::modulo_timer_src_e src_q;
   modulo_timer_pkg::modulo_timer_src_e src_d;
   logic [3:0]          ps_q;
   logic [3:0]          ps_d;
   logic                overflow_irq_enable_q;
   logic                overflow_irq_enable_d;
   logic [7:0]          mod_q;
   logic [7:0]          mod_d;

   // Count state
   logic [7:0]          cnt_q;
   logic [7:0]          cnt_d;
   logic [7:0]          pre_q;
   logic [7:0]          pre_d;

   // Flag state
   logic                tof_q;
   logic                tof_d;
   logic                arm_q;
   logic                arm_d;

   // Internal strobes
   logic                fix_rise;
   logic                pin_rise;
   logic                pin_fall;
   logic                src_tick;
   logic                tick;
   logic                wrap;
   logic                ovf;
   logic                trst_req;
   logic [3:0]          ps_eff;
   logic [7:0]          pre_mask;

   // Edge detectors for fixed clock and external pin
   modulo_timer_edge u_fix_edge (
      .clk   (clk),
      .rst_n (rst_s_n),
      .pin   (fixed_freq_clock),
      .rise  (fix_rise),
      .fall  ()
   );

   modulo_timer_edge u_pin_edge (
      .clk   (clk),
      .rst_n (rst_s_n),
      .pin   (external_count_pin),
      .rise  (pin_rise),
      .fall  (pin_fall)
   );

   // Configuration next values
   always_comb begin
      stop_d = stop_q;
      src_d  = src_q;
      ps_d   = ps_q;
      overflow_irq_enable_d = overflow_irq_enable_q;
      mod_d  = mod_q;
      if (ctrl_wr) begin
         stop_d = ctrl_data.counter_stop_bit;
         src_d  = modulo_timer_pkg::modulo_timer_src_e'(
                     ctrl_data.clock_source_select);
         ps_d   = ctrl_data.prescale_select;
         overflow_irq_enable_d = ctrl_data.overflow_irq_enable;
      end
      if (mod_wr) begin
         mod_d = mod_data;
      end
   end

   // Configuration registers
   always_ff @(posedge clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         stop_q <= 1'b1;
         src_q  <= modulo_timer_pkg::MODULO_TIMER_SRC_BUS;
         ps_q   <= `MODULO_TIMER_PS_RST;
         overflow_irq_enable_q <= 1'b0;
         mod_q  <= `MODULO_TIMER_MOD_RST;
      end else begin
         stop_q <= stop_d;
         src_q  <= src_d;
         ps_q   <= ps_d;
         overflow_irq_enable_q <= overflow_irq_enable_d;
         mod_q  <= mod_d;
      end
   end

   // Source select; switching never touches the count
   always_comb begin
      case (src_q)
         modulo_timer_pkg::MODULO_TIMER_SRC_BUS:      src_tick = 1'b1;
         modulo_timer_pkg::MODULO_TIMER_SRC_FIXED:    src_tick = fix_rise;
         modulo_timer_pkg::MODULO_TIMER_SRC_PIN_FALL: src_tick = pin_fall;
         modulo_timer_pkg::MODULO_TIMER_SRC_PIN_RISE: src_tick = pin_rise;
         default:                     src_tick = 1'b0;
      endcase
   end

   // Prescale mask; codes above eight act as divide by 256
   always_comb begin
      ps_eff   = (ps_q > `MODULO_TIMER_PS_MAX) ? `MODULO_TIMER_PS_MAX : ps_q;
      pre_mask = ~(`MODULO_TIMER_MASK_ALL << ps_eff);
      tick     = src_tick && ((pre_q & pre_mask) == pre_mask);
   end

   // Wrap point: modulo value, or top of range when modulo is zero
   always_comb begin
      trst_req = ctrl_wr && ctrl_data.counter_reset;
      if (mod_q == `MODULO_TIMER_MOD_RST) begin
         wrap = (cnt_q == `MODULO_TIMER_CNT_MAX);
      end else begin
         wrap = (cnt_q == mod_q);
      end
   end

   // Counter and prescaler next values
   always_comb begin
      cnt_d = cnt_q;
      pre_d = pre_q;
      ovf   = 1'b0;
      if (trst_req) begin
         cnt_d = `MODULO_TIMER_CNT_RST;
         pre_d = `MODULO_TIMER_PRE_RST;
      end else if (mod_wr && !stop_q) begin
         cnt_d = `MODULO_TIMER_CNT_RST;
         pre_d = `MODULO_TIMER_PRE_RST;
      end else if (!stop_q) begin
         if (src_tick) begin
            pre_d = pre_q + `MODULO_TIMER_CNT_INC;
         end
         if (tick) begin
            if (wrap) begin
               cnt_d = `MODULO_TIMER_CNT_RST;
               ovf   = 1'b1;
            end else begin
               cnt_d = cnt_q + `MODULO_TIMER_CNT_INC;
            end
         end
      end
   end

   // Counter and prescaler registers
   always_ff @(posedge clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         cnt_q <= `MODULO_TIMER_CNT_RST;
         pre_q <= `MODULO_TIMER_PRE_RST;
      end else begin
         cnt_q <= cnt_d;
         pre_q <= pre_d;
      end
   end

   // Overflow flag and two-step clear; a new overflow wins
   always_comb begin
      tof_d = tof_q;
      arm_d = arm_q;
      if (ovf) begin
         tof_d = 1'b1;
         arm_d = 1'b0;
      end else begin
         if (mod_wr || trst_req) begin
            tof_d = 1'b0;
         end else if (ctrl_wr && !ctrl_data.overflow_flag && arm_q) begin
            tof_d = 1'b0;
         end
         if (ctrl_wr || mod_wr) begin
            arm_d = 1'b0;
         end else if (status_rd && tof_q) begin
            arm_d = 1'b1;
         end
      end
   end

   // Flag registers
   always_ff @(posedge clk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         tof_q <= 1'b0;
         arm_q <= 1'b0;
      end else begin
         tof_q <= tof_d;
         arm_q <= arm_d;
      end
   end

   // Outputs; counter-reset bit always reads zero
   always_comb begin
      timer_status_control.overflow_flag       = tof_q;
      timer_status_control.overflow_irq_enable = overflow_irq_enable_q;
      timer_status_control.counter_reset       = 1'b0;
      timer_status_control.counter_stop_bit    = stop_q;
      timer_status_control.clock_source_select = src_q;
      timer_status_control.prescale_select     = ps_q;
   end

   assign count_value            = cnt_q;
   assign rollover_compare_value = mod_q;
   assign overflow_irq           = tof_q & overflow_irq_enable_q;

   // Checks on the counting path, flag clear and interrupt
   logic no_wr;
   assign no_wr = !ctrl_wr && !mod_wr;

   stop_hold_a: assert property (
      @(posedge clk) disable iff (!rst_s_n)
      stop_q && no_wr |=> $stable(cnt_q))
      else $error("counter moved while stopped");

   mod_wrap_a: assert property (
      @(posedge clk) disable iff (!rst_s_n)
      !stop_q && tick && no_wr && mod_q != `MODULO_TIMER_MOD_RST && cnt_q == mod_q
      |=> cnt_q == `MODULO_TIMER_CNT_RST && tof_q)
      else $error("no wrap at modulo value");

   free_wrap_a: assert property (
      @(posedge clk) disable iff (!rst_s_n)
      !stop_q && tick && no_wr && mod_q == `MODULO_TIMER_MOD_RST
      && cnt_q == `MODULO_TIMER_CNT_MAX
      |=> cnt_q == `MODULO_TIMER_CNT_RST && tof_q)
      else $error("free-running counter did not wrap");

   count_inc_a: assert property (
      @(posedge clk) disable iff (!rst_s_n)
      !stop_q && tick && no_wr && !wrap
      |=> cnt_q == $past(cnt_q) + `MODULO_TIMER_CNT_INC)
      else $error("counter did not increment");

   mod_write_a: assert property (
      @(posedge clk) disable iff (!rst_s_n)
      mod_wr && !ctrl_wr && !stop_q
      |=> cnt_q == `MODULO_TIMER_CNT_RST && !tof_q && mod_q == $past(mod_data))
      else $error("modulo write did not restart");

   clear_need_a: assert property (
      @(posedge clk) disable iff (!rst_s_n)
      tof_q && !arm_q && ctrl_wr && !ctrl_data.counter_reset && !mod_wr
      |=> tof_q)
      else $error("flag cleared without prior read");

   clear_done_a: assert property (
      @(posedge clk) disable iff (!rst_s_n)
      status_rd && tof_q && no_wr && !ovf
      ##1 ctrl_wr && !ctrl_data.overflow_flag && !ovf
      |=> !tof_q)
      else $error("read then write did not clear");

   clear_cancel_a: assert property (
      @(posedge clk) disable iff (!rst_s_n)
      arm_q && ovf ##1 ctrl_wr && !ctrl_data.counter_reset && !mod_wr
      |=> tof_q)
      else $error("clear not cancelled by overflow");

   trst_clear_a: assert property (
      @(posedge clk) disable iff (!rst_s_n)
      trst_req |=> cnt_q == `MODULO_TIMER_CNT_RST && pre_q == `MODULO_TIMER_PRE_RST && !tof_q)
      else $error("counter reset failed");

   irq_rise_a: assert property (
      @(posedge clk) disable iff (!rst_s_n)
      ovf && overflow_irq_enable_q && !ctrl_wr && !mod_wr |=> overflow_irq)
      else $error("interrupt missing on overflow");

   ps_clamp_a: assert property (
      @(posedge clk) disable iff (!rst_s_n)
      ps_q > `MODULO_TIMER_PS_MAX |-> pre_mask == `MODULO_TIMER_MASK_ALL)
      else $error("large prescale code not divide by 256");

   src_keep_a: assert property (
      @(posedge clk) disable iff (!rst_s_n)
      ctrl_wr && !ctrl_data.counter_reset && !mod_wr && !tick
      |=> cnt_q == $past(cnt_q))
      else $error("source change disturbed count");

   // Main scenarios
   wrap_c: cover property (@(posedge clk) disable iff (!rst_s_n)
      ovf && mod_q != `MODULO_TIMER_MOD_RST);
   clear_c: cover property (@(posedge clk) disable iff (!rst_s_n)
      arm_q && ctrl_wr && !ctrl_data.overflow_flag);
   cancel_c: cover property (@(posedge clk) disable iff (!rst_s_n)
      arm_q && ovf);
   pin_c: cover property (@(posedge clk) disable iff (!rst_s_n)
      ovf && src_q == modulo_timer_pkg::MODULO_TIMER_SRC_PIN_FALL);

endmodule : modulo_timer_core

//--- logic/modulo_timer_edge.sv
// Pin synchroniser with rising and falling edge pulses
`timescale 1ns/1ps
module modulo_timer_edge (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic pin,
   output logic      rise,
   output logic      fall
);

   logic sync1_q;
   logic sync2_q;
   logic last_q;
   logic rise_d;
   logic fall_d;

   // Edge compare on synchronised copies only
   always_comb begin
      rise_d = sync2_q & ~last_q;
      fall_d = ~sync2_q & last_q;
   end

   // Two-stage synchroniser plus history stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         last_q  <= 1'b0;
      end else begin
         sync1_q <= pin;
         sync2_q <= sync1_q;
         last_q  <= sync2_q;
      end
   end

   assign rise = rise_d;
   assign fall = fall_d;

   // Edge pulses last one cycle
   edge_pulse_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (rise |=> !rise) and (fall |=> !fall))
      else $error("edge pulse longer than one cycle");

endmodule : modulo_timer_edge

//--- testbench/modulo_timer_core_tb_top.sv
// Self-checking bench for the modulo timer core
`timescale 1ns/1ps
module modulo_timer_core_tb_top;
   logic                 clk;
   logic                 rst_n;
   logic                 fixed_freq_clock;
   logic                 external_count_pin;
   logic                 status_rd;
   logic                 ctrl_wr;
   modulo_timer_pkg::modulo_timer_ctrl_s ctrl_data;
   logic                 mod_wr;
   logic [7:0]           mod_data;
   modulo_timer_pkg::modulo_timer_stat_s stat;
   logic [7:0]           count_value;
   logic [7:0]           rollover_compare_value;
   logic                 overflow_irq;
   logic [7:0]           v;
   logic [9:0]           flag_cnt;
   int                   err_count;
   int                   n_checks;
   int                   cyc = 0;
   int                   n;

   modulo_timer_core i_modulo_timer_core (
      .clk                    (clk),
      .rst_n                  (rst_n),
      .fixed_freq_clock       (fixed_freq_clock),
      .external_count_pin     (external_count_pin),
      .status_rd              (status_rd),
      .ctrl_wr                (ctrl_wr),
      .ctrl_data              (ctrl_data),
      .mod_wr                 (mod_wr),
      .mod_data               (mod_data),
      .timer_status_control   (stat),
      .count_value            (count_value),
      .rollover_compare_value (rollover_compare_value),
      .overflow_irq           (overflow_irq)
   );

   // Flag and count seen together
   assign flag_cnt = {1'b0, stat.overflow_flag, count_value};

   // Free-running 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         $display("mismatch at %0t: timeout", $time);
         stop_test();
      end
   end

   task stop_test();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : stop_test

   task chk(input logic [9:0] got, input logic [9:0] exp, input string msg);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk

   task tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : tick

   task wr_ctrl(input logic f, input logic ie, input logic cr, input logic st,
                input logic [1:0] src, input logic [3:0] ps);
      @(posedge clk);
      #1;
      ctrl_data = modulo_timer_pkg::modulo_timer_ctrl_s'({f, ie, cr, st, src, ps});
      ctrl_wr = 1'b1;
      tick(1);
      ctrl_wr = 1'b0;
   endtask : wr_ctrl

   task wr_mod(input logic [7:0] d);
      @(posedge clk);
      #1;
      mod_data = d;
      mod_wr = 1'b1;
      tick(1);
      mod_wr = 1'b0;
   endtask : wr_mod

   task rd_stat();
      @(posedge clk);
      #1;
      status_rd = 1'b1;
      tick(1);
      status_rd = 1'b0;
   endtask : rd_stat

   // Wait until the count shows a given value
   task wait_cnt(input logic [7:0] t);
      n = 0;
      while (count_value !== t && n < 600) begin
         tick(1);
         n++;
      end
   endtask : wait_cnt

   // Count cycles until the count moves
   task wait_chg();
      v = count_value;
      n = 0;
      while (count_value === v && n < 600) begin
         tick(1);
         n++;
      end
   endtask : wait_chg

   // Main sequence
   initial begin
      {rst_n, fixed_freq_clock, external_count_pin} = 3'b000;
      {status_rd, ctrl_wr, mod_wr, err_count, n_checks} = '0;
      ctrl_data = '0;
      mod_data = 8'h00;
      tick(10);
      rst_n = 1'b1;
      tick(3);
      chk(stat, 10'h040, "reset readback");
      chk(10'(count_value | rollover_compare_value), 10'h000, "rst");
      $display("reset test done");
      wr_ctrl(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 4'h0);
      chk(10'(stat.counter_stop_bit), 10'h000, "started");
      wait_cnt(8'hff);
      chk(10'(stat.overflow_flag), 10'h000, "no flag before wrap");
      tick(1);
      chk(flag_cnt, 10'h100, "free wrap");
      $display("free-run test done");
      wr_mod(8'h03);
      chk(flag_cnt, 10'h000, "mod write restarts");
      chk(10'(rollover_compare_value), 10'h003, "mod readback");
      wait_cnt(8'h03);
      chk(10'(stat.overflow_flag), 10'h000, "flag at match");
      tick(1);
      chk(flag_cnt, 10'h100, "mod wrap");
      $display("modulo test done");
      wr_ctrl(1'b1, 1'b0, 1'b0, 1'b1, 2'h0, 4'h0);
      wr_ctrl(1'b0, 1'b0, 1'b0, 1'b1, 2'h0, 4'h0);
      chk(10'(stat.overflow_flag), 10'h001, "clear without read");
      // Read, then zero write in the very next cycle
      rd_stat();
      ctrl_data = modulo_timer_pkg::modulo_timer_ctrl_s'(10'h040);
      ctrl_wr = 1'b1;
      tick(1);
      ctrl_wr = 1'b0;
      chk(10'(stat.overflow_flag), 10'h000, "read then clear");
      // Overflow lands between the read and the write
      wr_ctrl(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 4'h0);
      tick(7);
      rd_stat();
      wr_ctrl(1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 4'h0);
      chk(10'(stat.overflow_flag), 10'h001, "overflow cancels");
      $display("flag clear test done");
      wr_ctrl(1'b1, 1'b0, 1'b1, 1'b1, 2'h0, 4'h0);
      chk(flag_cnt, 10'h000, "counter reset");
      chk(10'(stat.counter_reset), 10'h000, "reset bit reads zero");
      wr_ctrl(1'b1, 1'b1, 1'b0, 1'b0, 2'h0, 4'h0);
      chk(10'(overflow_irq), 10'h000, "no irq without flag");
      chk(10'(stat.overflow_irq_enable), 10'h001, "enable readback");
      tick(5);
      chk(10'(stat.overflow_flag), 10'h001, "flag for irq");
      chk(10'(overflow_irq), 10'h001, "irq raised");
      wr_ctrl(1'b1, 1'b0, 1'b0, 1'b1, 2'h0, 4'h0);
      chk(10'(overflow_irq), 10'h000, "irq masked");
      v = count_value;
      wr_mod(8'h00);
      chk(flag_cnt, {2'b00, v}, "mod write when stopped");
      $display("irq test done");
      // Divide ratios, codes 9 and up behave as 256
      for (int ps = 0; ps < 10; ps++) begin
         wr_ctrl(1'b1, 1'b0, 1'b1, 1'b0, 2'h0, 4'(ps));
         chk(10'(stat.prescale_select), 10'(ps), "prescale readback");
         wait_chg();
         wait_chg();
         chk(10'(n), 10'(1 << (ps > 8 ? 8 : ps)), "divide ratio");
      end
      wait_chg();
      v = count_value;
      wr_ctrl(1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 4'h0);
      chk(10'(count_value), {2'b00, v}, "prescale change keeps");
      tick(1);
      chk(10'(count_value), {2'b00, v + 8'h01}, "new rate");
      $display("prescaler test done");
      v = count_value;
      wr_ctrl(1'b1, 1'b0, 1'b0, 1'b0, 2'h3, 4'h0);
      chk(10'(count_value), {2'b00, v + 8'h02}, "source kept");
      chk(10'(stat.clock_source_select), 10'h003, "source readback");
      tick(4);
      v = count_value;
      external_count_pin = 1'b1;
      tick(6);
      chk(10'(count_value), {2'b00, v + 8'h01}, "pin rise counted");
      external_count_pin = 1'b0;
      tick(6);
      chk(10'(count_value), {2'b00, v + 8'h01}, "fall ignored");
      wr_ctrl(1'b1, 1'b0, 1'b0, 1'b0, 2'h2, 4'h0);
      external_count_pin = 1'b1;
      tick(6);
      chk(10'(count_value), {2'b00, v + 8'h01}, "rise ignored");
      external_count_pin = 1'b0;
      tick(6);
      chk(10'(count_value), {2'b00, v + 8'h02}, "pin fall counted");
      wr_ctrl(1'b1, 1'b0, 1'b0, 1'b0, 2'h1, 4'h0);
      repeat (3) begin
         fixed_freq_clock = 1'b1;
         tick(3);
         fixed_freq_clock = 1'b0;
         tick(3);
      end
      tick(3);
      chk(10'(count_value), {2'b00, v + 8'h05}, "fixed clock");
      $display("source test done");
      stop_test();
   end
endmodule : modulo_timer_core_tb_top
